// ---- src/tgd_cfg.svh ----
// Constants of the tall glyph RAM and segment drive block.
// Assumes inclusion by bare name; definitions only.
// What this block does
// - Tall font glyph takes eleven rows; RAM address bits 5:4 from code bits 2:1.
// - Tall font ignores code bits 0 and 3 when choosing a user glyph.
// - Glyph RAM address bits 3:0 pick the row in the tall font, bits 2:0 in the short font; row zero is on top.
// - Cursor ORs all ones into the bottom displayed row of its character.
// - Only bits 4:0 of a glyph byte are pixel data.
// - Pixel bit one lights the panel pixel, zero leaves it dark.
// - Bits 7:5 are stored and read back but never displayed.
// - In the tall font, rows 1011 to 1111 are never fetched, yet stay host readable and writable.
// - Display fetches run on their own timing, apart from host accesses.
// - Timing generator makes sequencing strobes plus cascade shift and latch pulses.
// - Sixteen common outputs and eighty segment outputs.
// - Active commons follow font height and number of lines.
// - Each row is shifted into an 80-bit register, then latched to segments.
// - Shift starts from leftmost or rightmost pixel per direction select.
// - Row bits pass to a serial output; register keeps the last 80 bits.
`ifndef TGD_CFG_SVH
`define TGD_CFG_SVH
`define TGD_GLYPH_DEPTH 64
`define TGD_CC_DEPTH    80
`define TGD_SEG_W       80
`define TGD_COM_W       16
`define TGD_LINE2_BASE  7'h28
`define TGD_LAST_COL    4'hf
`define TGD_LAST_BIT    3'h4
`define TGD_TALL_LAST   4'ha
`define TGD_SHORT_LAST  4'h7
`define TGD_TWO_LAST    4'hf
`define TGD_CURSOR_ROW  5'h1f
`endif

// ---- src/tgd_glyph_drive.sv ----
// Glyph RAM, character code RAM, row fetch and segment/common drive.
// Assumes synchronous inputs on clk and a glyph ROM answering one cycle after romAddr.
`include "tgd_cfg.svh"
module tgd_glyph_drive (
    input  wire logic        clk,            // 250 MHz device clock
    input  wire logic        nrst,           // Async reset, active low
    input  wire logic        hostReq,        // Glyph RAM access, held until hostAck
    input  wire logic        hostWe,         // Write when high, read when low
    input  wire logic [5:0]  hostAddr,       // Glyph RAM byte address
    input  wire logic [7:0]  hostWdata,      // Write byte
    output logic      [7:0]  hostRdata,      // Read byte, valid with hostAck
    output logic             hostAck,        // One-cycle access done pulse
    input  wire logic        ccWe,           // Character code RAM write strobe
    input  wire logic [6:0]  ccAddr,         // Character code RAM address
    input  wire logic [7:0]  ccWdata,        // Character code
    input  wire logic        tallFont,       // 5x10 font selected
    input  wire logic        twoLine,        // Two display lines (short font only)
    input  wire logic        cursorOn,       // Cursor shown
    input  wire logic [6:0]  cursorPos,      // Cursor character address
    input  wire logic        shiftDirSel,    // Zero: leftmost pixel first
    output logic      [11:0] romAddr,        // Glyph ROM address {code,row}
    input  wire logic [4:0]  romData,        // Glyph ROM row pixels
    output logic      [79:0] seg,            // Segment outputs
    output logic      [15:0] com,            // Common outputs
    output logic             serialOut,      // Shift register serial output
    output logic             shiftClk,       // Cascade shift strobe
    output logic             latchPulse      // Cascade latch strobe
);
    logic [7:0]  glyphRam [`TGD_GLYPH_DEPTH];
    logic [7:0]  ccRam [`TGD_CC_DEPTH];
    tgd_pkg::tgd_state_t stFf, nxt_st;
    logic        slotFf, nxt_slot, ackFf, nxt_ack, shClkFf, nxt_shClk, latFf, nxt_lat;
    logic [3:0]  scanFf, nxt_scan, colFf, nxt_col;
    logic [2:0]  bitFf, nxt_bit;
    logic [7:0]  codeFf, nxt_code, gDataFf, nxt_gData, rdFf, nxt_rd;
    logic [11:0] romFf, nxt_rom;
    logic [79:0] shFf, nxt_sh, segFf, nxt_seg;
    logic [15:0] comFf, nxt_com;
    logic        dispSlot, lineSel, isUser, bottom, pixBit;
    logic [3:0]  rowIdx, colIdx, lastScan;
    logic [5:0]  gAddr;
    logic [6:0]  charAddr;
    logic [4:0]  pix;
    logic [2:0]  bitIdx;

    // Even slots belong to the display, odd ones to the host
    assign dispSlot = ~slotFf;
    assign lineSel  = twoLine & ~tallFont & scanFf[3];
    assign rowIdx   = tallFont ? scanFf : {1'b0, scanFf[2:0]};
    assign lastScan = tallFont ? `TGD_TALL_LAST : (twoLine ? `TGD_TWO_LAST : `TGD_SHORT_LAST);
    assign colIdx   = shiftDirSel ? (`TGD_LAST_COL - colFf) : colFf;
    assign charAddr = (lineSel ? `TGD_LINE2_BASE : 7'h00) + {3'h0, colIdx};
    // Tall glyphs drop code bits 0 and 3; rows beyond 1010 are never reached
    assign gAddr    = tallFont ? {codeFf[2:1], rowIdx}
                               : {codeFf[2:0], rowIdx[2:0]};
    assign isUser   = codeFf[7:4] == 4'h0;
    assign bottom   = rowIdx == (tallFont ? `TGD_TALL_LAST : `TGD_SHORT_LAST);
    // Only the five low bits are pixels; a one lights the dot
    assign pix      = (isUser ? gDataFf[4:0] : romData)
                    | ((cursorOn && bottom && charAddr == cursorPos) ? `TGD_CURSOR_ROW
                                                                      : 5'h00);
    assign bitIdx   = shiftDirSel ? bitFf : (`TGD_LAST_BIT - bitFf);
    assign pixBit   = pix[bitIdx];

    // Host side of the glyph RAM, served only in host slots
    always_comb begin
        nxt_slot = ~slotFf;
        nxt_ack  = hostReq && !dispSlot && !ackFf;
        nxt_rd   = rdFf;
        if (nxt_ack) begin
            nxt_rd = hostWe ? hostWdata : glyphRam[hostAddr];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            slotFf <= 1'b0;
            ackFf  <= 1'b0;
            rdFf   <= 8'h00;
        end else begin
            slotFf <= nxt_slot;
            ackFf  <= nxt_ack;
            rdFf   <= nxt_rd;
        end
    end

    // Memories carry no reset; full bytes kept for general storage
    always_ff @(posedge clk) begin
        if (nxt_ack && hostWe) begin
            glyphRam[hostAddr] <= hostWdata;
        end
        if (ccWe) begin
            ccRam[ccAddr] <= ccWdata;
        end
    end

    // Row sequencer: code fetch, glyph fetch, five shifts per character, latch
    always_comb begin
        nxt_st    = stFf;
        nxt_scan  = scanFf;
        nxt_col   = colFf;
        nxt_bit   = bitFf;
        nxt_code  = codeFf;
        nxt_gData = gDataFf;
        nxt_rom   = romFf;
        nxt_sh    = shFf;
        nxt_seg   = segFf;
        nxt_com   = comFf;
        nxt_shClk = 1'b0;
        nxt_lat   = 1'b0;
        if (dispSlot) begin
            case (stFf)
                tgd_pkg::ST_CODE: begin
                    nxt_code = ccRam[charAddr];
                    nxt_st   = tgd_pkg::ST_GLYPH;
                end
                tgd_pkg::ST_GLYPH: begin
                    nxt_gData = glyphRam[gAddr];
                    nxt_rom   = {codeFf, rowIdx};
                    nxt_bit   = 3'h0;
                    nxt_st    = tgd_pkg::ST_SHIFT;
                end
                tgd_pkg::ST_SHIFT: begin
                    // Bits ripple out of the top for cascaded drivers
                    nxt_sh    = {shFf[78:0], pixBit};
                    nxt_shClk = 1'b1;
                    nxt_bit   = bitFf + 3'h1;
                    if (bitFf == `TGD_LAST_BIT) begin
                        nxt_col = colFf + 4'h1;
                        nxt_st  = (colFf == `TGD_LAST_COL) ? tgd_pkg::ST_LATCH
                                                           : tgd_pkg::ST_CODE;
                    end
                end
                default: begin
                    // Segments and commons change together to avoid ghosting
                    nxt_seg  = shFf;
                    nxt_com  = 16'h0001 << scanFf;
                    nxt_lat  = 1'b1;
                    nxt_scan = (scanFf >= lastScan) ? 4'h0 : scanFf + 4'h1;
                    nxt_col  = 4'h0;
                    nxt_st   = tgd_pkg::ST_CODE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stFf    <= tgd_pkg::ST_CODE;
            scanFf  <= 4'h0;
            colFf   <= 4'h0;
            bitFf   <= 3'h0;
            codeFf  <= 8'h00;
            gDataFf <= 8'h00;
            romFf   <= 12'h000;
            shFf    <= 80'h0;
            segFf   <= 80'h0;
            comFf   <= 16'h0000;
            shClkFf <= 1'b0;
            latFf   <= 1'b0;
        end else begin
            stFf    <= nxt_st;
            scanFf  <= nxt_scan;
            colFf   <= nxt_col;
            bitFf   <= nxt_bit;
            codeFf  <= nxt_code;
            gDataFf <= nxt_gData;
            romFf   <= nxt_rom;
            shFf    <= nxt_sh;
            segFf   <= nxt_seg;
            comFf   <= nxt_com;
            shClkFf <= nxt_shClk;
            latFf   <= nxt_lat;
        end
    end

    // Outputs straight from flip-flops
    assign hostRdata  = rdFf;
    assign hostAck    = ackFf;
    assign romAddr    = romFf;
    assign seg        = segFf;
    assign com        = comFf;
    assign serialOut  = shFf[79];
    assign shiftClk   = shClkFf;
    assign latchPulse = latFf;

    // Checks
    host_slot_a: assert property (@(posedge clk) disable iff (!nrst)
        hostAck |-> $past(slotFf) && $past(hostReq))
        else $error("host served in display slot");
    fetch_timing_a: assert property (@(posedge clk) disable iff (!nrst)
        (stFf != $past(stFf)) |-> $past(dispSlot))
        else $error("sequencer moved in host slot");
    tall_rows_a: assert property (@(posedge clk) disable iff (!nrst)
        (tallFont && stFf == tgd_pkg::ST_GLYPH && dispSlot) |-> gAddr[3:0] <= 4'ha)
        else $error("unused tall row fetched");
    tall_addr_a: assert property (@(posedge clk) disable iff (!nrst)
        tallFont |-> gAddr[5:4] == codeFf[2:1])
        else $error("tall glyph address wrong");
    com_onehot_a: assert property (@(posedge clk) disable iff (!nrst)
        $onehot0(com))
        else $error("more than one common active");
    com_range_a: assert property (@(posedge clk) disable iff (!nrst)
        (latchPulse && $past(tallFont, 2) && tallFont) |-> com[15:11] == 5'h00)
        else $error("tall font scanned too many commons");
    latch_copy_a: assert property (@(posedge clk) disable iff (!nrst)
        latchPulse |-> seg == $past(shFf))
        else $error("segments not latched from shift register");
    shift_pass_a: assert property (@(posedge clk) disable iff (!nrst)
        shiftClk |-> shFf[79:1] == $past(shFf[78:0]))
        else $error("shift register did not shift");
    cursor_row_a: assert property (@(posedge clk) disable iff (!nrst)
        (dispSlot && stFf == tgd_pkg::ST_SHIFT && cursorOn && bottom
         && charAddr == cursorPos) |=> shFf[0])
        else $error("cursor pixel not forced on");

    // Host handshake: one pulse per access, bytes stored whole
    ack_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
        hostAck |=> !hostAck)
        else $error("access done pulse longer than one cycle");

    write_echo_a: assert property (@(posedge clk) disable iff (!nrst)
        (hostAck && $past(hostWe)) |-> hostRdata == $past(hostWdata))
        else $error("written byte not echoed");

    read_data_a: assert property (@(posedge clk) disable iff (!nrst)
        (hostAck && !$past(hostWe)) |-> hostRdata == $past(glyphRam[hostAddr]))
        else $error("read byte differs from stored byte");

    // Row select comes straight from the scan in the tall font
    row_addr_a: assert property (@(posedge clk) disable iff (!nrst)
        tallFont |-> gAddr[3:0] == scanFf)
        else $error("tall row address not from scan");

    // Pixel path uses the five low bits only
    pix_width_a: assert property (@(posedge clk) disable iff (!nrst)
        (stFf == tgd_pkg::ST_SHIFT && isUser && !cursorOn) |-> pix == gDataFf[4:0])
        else $error("upper glyph bits reached pixels");

    // Cascade tap follows the top of the shift register
    serial_tap_a: assert property (@(posedge clk) disable iff (!nrst)
        shiftClk |-> serialOut == $past(shFf[78]))
        else $error("serial output not from shift register");

    // Strobes stay single-cycle and never overlap
    shift_rate_a: assert property (@(posedge clk) disable iff (!nrst)
        shiftClk |=> !shiftClk)
        else $error("shift strobe too long");

    latch_alone_a: assert property (@(posedge clk) disable iff (!nrst)
        latchPulse |-> !shiftClk)
        else $error("latch and shift strobes overlap");

    row_latched_c: cover property (@(posedge clk) disable iff (!nrst) latchPulse);
    cursor_hit_c: cover property (@(posedge clk) disable iff (!nrst)
        dispSlot && stFf == tgd_pkg::ST_SHIFT && cursorOn && bottom && charAddr == cursorPos);
    mirror_row_c: cover property (@(posedge clk) disable iff (!nrst)
        shiftDirSel && latchPulse);
    host_write_c: cover property (@(posedge clk) disable iff (!nrst) hostAck && $past(hostWe));
    tall_wrap_c: cover property (@(posedge clk) disable iff (!nrst)
        tallFont && latchPulse && com[10]);
endmodule

// ---- src/tgd_pkg.sv ----
// Types shared by the tall glyph RAM and segment drive block.
// Assumes nothing beyond a SystemVerilog compiler.
package tgd_pkg;
    typedef enum logic [1:0] {ST_CODE, ST_GLYPH, ST_SHIFT, ST_LATCH} tgd_state_t;
endpackage

// ---- tb/tgd_glyph_drive_test.sv ----
// Self-checking bench for glyph RAM access and segment/common drive.
// Assumes the host model above and a glyph ROM modelled here.
module tgd_glyph_drive_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, nrst, hostReq, hostWe, hostAck, ccWe, tallFont, twoLine, cursorOn;
    logic        shiftDirSel, serialOut, shiftClk, latchPulse;
    logic [5:0]  hostAddr;
    logic [7:0]  hostWdata, hostRdata, ccWdata;
    logic [6:0]  ccAddr, cursorPos;
    logic [11:0] romAddr;
    logic [4:0]  romData;
    logic [79:0] seg;
    logic [15:0] com;
    logic [7:0]  gm [64];
    logic [7:0]  ccm [80];
    logic [7:0]  q [$];
    logic [31:0] rs = 32'ha37b;
    int          failures, num_checks, row, shCnt;
    int          skip = 1000;
    // Clock at 4 ns period
    always #2 clk = ~clk;
    // Glyph ROM stand-in, one cycle latency
    function automatic logic [4:0] romf(input logic [11:0] a);
        return a[4:0] ^ a[11:7];
    endfunction
    always @(posedge clk) romData <= romf(romAddr);
    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task automatic chk(input logic [79:0] e, input logic [79:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    // Expected row bitmap, char 0 in the top bits unless mirrored
    function automatic logic [79:0] expSeg(input int r);
        logic [79:0] e;
        logic [79:0] f;
        logic [7:0]  cd;
        logic [4:0]  p;
        int          rr;
        int          base;
        // Short font folds the scan onto eight rows; line two starts at 40
        rr = tallFont ? r : r % 8;
        base = (!tallFont && twoLine && r >= 8) ? 40 : 0;
        for (int c = 0; c < 16; c++) begin
            cd = ccm[base + c];
            if (cd >= 8'h10) p = romf({cd, rr[3:0]});
            else if (tallFont) p = gm[{cd[2:1], rr[3:0]}][4:0];
            else p = gm[{cd[2:0], rr[2:0]}][4:0];
            if (cursorOn && cursorPos == base + c && rr == (tallFont ? 10 : 7)) p = p | 5'h1f;
            e[79 - 5 * c -: 5] = p;
        end
        for (int i = 0; i < 80; i++) f[i] = e[79 - i];
        return shiftDirSel ? f : e;
    endfunction
    task automatic finish_test;
        if (q.size() != 0) failures++;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Host access: note the expected byte, then run the handshake
    task automatic hst(input logic we, input logic [5:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = we ? tgd_host_model_inst.keep(a, d) : d;
        if (we) gm[a] = v;
        q.push_back(gm[a]);
        tgd_host_model_inst.access(we, a, v);
    endtask
    tgd_glyph_drive tgd_glyph_drive_inst (.clk(clk), .nrst(nrst), .hostReq(hostReq),
        .hostWe(hostWe), .hostAddr(hostAddr), .hostWdata(hostWdata), .hostRdata(hostRdata),
        .hostAck(hostAck), .ccWe(ccWe), .ccAddr(ccAddr), .ccWdata(ccWdata),
        .tallFont(tallFont), .twoLine(twoLine), .cursorOn(cursorOn), .cursorPos(cursorPos),
        .shiftDirSel(shiftDirSel), .romAddr(romAddr), .romData(romData), .seg(seg),
        .com(com), .serialOut(serialOut), .shiftClk(shiftClk), .latchPulse(latchPulse));
    tgd_host_model tgd_host_model_inst (.clk(clk), .hostAck(hostAck), .hostReq(hostReq),
        .hostWe(hostWe), .hostAddr(hostAddr), .hostWdata(hostWdata));
    // Watcher: ack bytes against the queue, each latched row once skip has run out against the model
    always @(posedge clk) begin
        if (nrst) begin
            if (hostAck === 1'b1) chk(q.size() ? q.pop_front() : 8'hxx, hostRdata);
            if (shiftClk === 1'b1) shCnt++;
            if (latchPulse === 1'b1) begin
                if (skip == 0) begin
                    chk(expSeg(row), seg);
                    chk(80'h1 << row, com);
                    chk(80'd80, shCnt);
                end else skip--;
                row = (row >= (tallFont ? 10 : (twoLine ? 15 : 7))) ? 0 : row + 1;
                shCnt = 0;
            end
        end
    end
    // Main sequence
    initial begin
        logic [31:0] r;
        logic [7:0]  cd;
        {clk, nrst, ccWe, ccAddr, ccWdata, twoLine, cursorOn, cursorPos, shiftDirSel} = '0;
        tallFont = 1'b1;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 128; i++) hst(i < 64, i[5:0], xs());
        for (int c = 0; c < 80; c++) begin
            r = xs();
            cd = r[8] ? {4'h0, r[3:0]} : r[7:0];
            ccWe <= 1'b1;
            ccAddr <= c[6:0];
            ccWdata <= cd;
            ccm[c] = cd;
            @(posedge clk);
        end
        ccWe <= 1'b0;
        // Each mirror/cursor mode, with host writes on unshown rows and reads at any address meanwhile
        // Modes change just after a latch so the row count stays aligned
        for (int m = 0; m < 8; m++) begin
            @(posedge clk iff latchPulse === 1'b1);
            r = xs();
            tallFont <= ~m[2];
            shiftDirSel <= m[0];
            cursorOn <= m[1];
            cursorPos <= {3'h0, r[3:0]};
            twoLine <= r[4];
            skip = 2;
            repeat (700) begin
                r = xs();
                // Writes only in tall mode, where rows 11 to 15 are never shown
                hst(r[9] && m < 4, r[9] ? {r[5:4], 4'hb + (r[2:0] % 3'd5)} : r[5:0], r[31:24]);
            end
        end
        finish_test;
    end
    // Watchdog
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        finish_test;
    end
endmodule

// ---- tb/tgd_host_model.sv ----
// Host model: one glyph RAM access at a time over the req/ack handshake.
// Assumes calls start right after a rising edge, with reset released.
module tgd_host_model (
    input  wire logic       clk,       // Device clock
    input  wire logic       hostAck,   // Access done pulse
    output logic            hostReq,   // Held until ack
    output logic            hostWe,    // High for write
    output logic      [5:0] hostAddr,  // Glyph byte address
    output logic      [7:0] hostWdata  // Write byte
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle lines at time zero
    initial begin
        {hostReq, hostWe, hostAddr, hostWdata} = '0;
    end
    // Row 10 kept clear so a cursor hides no glyph pixels
    function automatic logic [7:0] keep(input logic [5:0] a, input logic [7:0] d);
        return (a[3:0] == 4'ha) ? 8'h00 : d;
    endfunction
    // Hold request until ack is sampled; released lines show inverted junk
    task automatic access(input logic we, input logic [5:0] a, input logic [7:0] d);
        int n;
        n = 0;
        hostReq <= 1'b1;
        hostWe <= we;
        hostAddr <= a;
        hostWdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (hostAck !== 1'b1 && n < 8);
        hostReq <= 1'b0;
        hostWe <= ~we;
        hostAddr <= ~a;
        hostWdata <= ~d;
        @(posedge clk); // Gap so the next request is a fresh edge
    endtask
endmodule
